// >>> design/osc_ctrl_pkg.sv
/*
 * Shared constants, types and decode functions for the system clock
 * source control block. Assumes a 40 MHz system clock and APB access.
 */
package osc_ctrl_pkg;

    // clock rates
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int HF_OSC_HZ = 8_000_000;
    localparam int LF_OSC_HZ = 31_000;
    localparam int HF_BASE_DIV = CLK_HZ / HF_OSC_HZ;
    localparam int LF_DIV = CLK_HZ / LF_OSC_HZ;
    localparam int PS_W = 11;

    // oscillator warm-up times and their cycle counts (rounded up)
    localparam int HF_WARM_NS = 2000;
    localparam int LF_WARM_NS = 2000;
    localparam int HF_WARM_CYC = (HF_WARM_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int LF_WARM_CYC = (LF_WARM_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int WARM_W = 8;

    // crystal start-up timer, power-up timer and fail-safe timeout
    localparam int XTAL_STARTUP_COUNT = 1024;
    localparam int XTAL_STARTUP_W = 11;
    localparam int MONITOR_TIMEOUT_CYC = 2 * LF_DIV;
    localparam int POWER_UP_CYC = 2048;
    localparam int CNT_W = 16;

    // register map
    localparam logic [11:0] OSC_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] FAIL_STATUS_OFFSET = 12'h004;
    localparam int FREQ_SEL_LSB = 4;
    localparam int FREQ_SEL_MSB = 6;
    localparam int STARTUP_STATUS_BIT = 3;
    localparam int HF_STABLE_BIT = 2;
    localparam int LF_STABLE_BIT = 1;
    localparam int CLK_SEL_BIT = 0;
    localparam int FAIL_BIT = 0;
    localparam logic [2:0] FREQ_SEL_RESET = 3'h6;
    localparam logic [2:0] FREQ_SEL_LF = 3'h0;
    localparam logic [2:0] FREQ_SEL_MAX = 3'h7;

    typedef enum logic [2:0] {
        LOW_POWER_CRYSTAL_MODE = 3'h0,
        MEDIUM_GAIN_CRYSTAL_MODE = 3'h1,
        HIGH_GAIN_CRYSTAL_MODE = 3'h2,
        EXTERNAL_LOGIC_CLOCK_MODE = 3'h3,
        INTERNAL_OSC_IO_MODE = 3'h4,
        INTERNAL_OSC_DIVIDED_CLOCK_OUT_MODE = 3'h5,
        RESISTOR_NET_IO_MODE = 3'h6,
        RESISTOR_CAPACITOR_MODE = 3'h7
    } osc_mode_t;

    typedef enum logic [4:0] {
        ST_POWER_UP = 5'h01,
        ST_XTAL_WAIT = 5'h02,
        ST_RUN = 5'h04,
        ST_SW_OLD = 5'h08,
        ST_SW_NEW = 5'h10
    } clk_state_t;

    function automatic logic is_crystal(input osc_mode_t m);
        return m == LOW_POWER_CRYSTAL_MODE || m == MEDIUM_GAIN_CRYSTAL_MODE
            || m == HIGH_GAIN_CRYSTAL_MODE;
    endfunction

    function automatic logic is_internal_mode(input osc_mode_t m);
        return m == INTERNAL_OSC_IO_MODE || m == INTERNAL_OSC_DIVIDED_CLOCK_OUT_MODE;
    endfunction

    function automatic logic has_divided_clock_out(input osc_mode_t m);
        return m == RESISTOR_CAPACITOR_MODE || m == INTERNAL_OSC_DIVIDED_CLOCK_OUT_MODE;
    endfunction

endpackage

// >>> design/osc_postscaler.sv
/*
 * Internal oscillator postscaler: one-cycle tick at the rate chosen by
 * the frequency select code. Assumes a 40 MHz clock; restarts its count
 * whenever the select code changes, so the first tick marks a clean
 * rising edge of the new rate.
 */
`timescale 1ns/1ps
`default_nettype none
module osc_postscaler
    import osc_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic [2:0] i_sel,
    output logic o_tick
);
    logic [PS_W-1:0] cnt_reg;
    logic [2:0] sel_reg;
    logic [PS_W-1:0] limit;
    logic wrap;

    assign limit = (i_sel == FREQ_SEL_LF) ? PS_W'(LF_DIV - 1)
        : PS_W'((HF_BASE_DIV << (FREQ_SEL_MAX - i_sel)) - 1);
    assign wrap = (cnt_reg == limit);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= '0;
            sel_reg <= FREQ_SEL_RESET;
            o_tick <= 1'b0;
        end else begin
            sel_reg <= i_sel;
            o_tick <= i_run && wrap && (sel_reg == i_sel);
            if (!i_run || sel_reg != i_sel || wrap) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + PS_W'(1);
            end
        end
    end
endmodule // osc_postscaler
`default_nettype wire

// >>> design/system_clock_source_control.sv
/*
 * System clock source selection and start-up control with an APB slave
 * for the oscillator control and fail status registers. Assumes every input synchronous
 * to the 40 MHz clock; oscillators are seen as tick enables.
 */
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control
    import osc_ctrl_pkg::*;
#(
    parameter int POWER_UP_CYCLES = POWER_UP_CYC,
    parameter int MONITOR_TIMEOUT = MONITOR_TIMEOUT_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire osc_ctrl_pkg::osc_mode_t i_osc_mode,
    input wire logic i_two_speed_en,
    input wire logic i_failsafe_en,
    input wire logic i_power_up_timer_en,
    input wire logic i_wake,
    input wire logic i_osc_input_pin,
    output logic o_sys_clk_en,
    output logic o_cpu_hold,
    output logic o_divided_clock_out,
    output logic o_osc_output_pin_oe,
    output logic o_osc_output_pin_gpio,
    output logic o_osc_input_pin_gpio,
    output logic o_clk_internal
);
    import osc_ctrl_pkg::*;

    clk_state_t state_reg, state_next;
    logic [2:0] freq_sel_reg, cur_freq_sel_reg;
    logic clk_sel_reg, cur_int_reg, fail_reg, startup_status_reg, boot_reg;
    logic osc_in_reg, hf_stable_reg, lf_stable_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] monitor_gap_reg;
    logic [WARM_W-1:0] hf_warm_reg, lf_warm_reg;
    logic [1:0] div_reg;

    // bus decode
    wire setup = i_psel && !i_penable;
    wire wr_done = i_psel && i_penable && o_pready && i_pwrite;
    wire hit_ctrl = (i_paddr == OSC_CTRL_OFFSET);
    wire hit_fail = (i_paddr == FAIL_STATUS_OFFSET);
    wire wr_ctrl = wr_done && hit_ctrl;
    wire clr_fail = wr_done && hit_fail && i_pwdata[FAIL_BIT];

    wire crystal = is_crystal(i_osc_mode);
    wire int_mode = is_internal_mode(i_osc_mode);
    wire want_int = int_mode || clk_sel_reg || fail_reg
        || ((state_reg == ST_XTAL_WAIT) && i_two_speed_en);
    wire src_change = (want_int != cur_int_reg)
        || (cur_int_reg && freq_sel_reg != cur_freq_sel_reg);

    // external edges and internal postscaler ticks
    wire ext_tick = i_osc_input_pin && !osc_in_reg;
    logic int_tick;
    wire int_run = cur_int_reg || want_int;
    osc_postscaler u_postscaler (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_run(int_run),
        .i_sel(cur_freq_sel_reg),
        .o_tick(int_tick)
    );
    wire cur_tick = cur_int_reg ? int_tick : ext_tick;

    // oscillator enables and stability
    wire lf_sel = (freq_sel_reg == FREQ_SEL_LF);
    wire hf_on = want_int && !lf_sel;
    wire lf_on = (want_int && lf_sel) || i_power_up_timer_en || i_failsafe_en
        || (i_two_speed_en && lf_sel);
    wire new_stable = lf_sel ? lf_stable_reg : hf_stable_reg;

    // value loaded in place of a reset value
    wire startup_status_boot = !((i_two_speed_en && crystal)
        || i_failsafe_en);
    wire run_ext = !cur_int_reg && (state_reg == ST_RUN
        || state_reg == ST_SW_OLD);
    wire hold = (state_reg == ST_POWER_UP) || (state_reg == ST_SW_NEW)
        || ((state_reg == ST_XTAL_WAIT) && !i_two_speed_en);

    wire monitor_trip = i_failsafe_en && !cur_int_reg && !fail_reg
        && (monitor_gap_reg >= CNT_W'(MONITOR_TIMEOUT));
    wire cnt_done_power_up = (cnt_reg >= CNT_W'(POWER_UP_CYCLES));
    wire cnt_done_xtal = (cnt_reg >= CNT_W'(XTAL_STARTUP_COUNT));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_POWER_UP: begin
                if (!i_power_up_timer_en || cnt_done_power_up) begin
                    state_next = crystal ? ST_XTAL_WAIT : ST_RUN;
                end
            end
            ST_XTAL_WAIT: begin
                if (cnt_done_xtal || fail_reg) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (i_wake && crystal) begin
                    state_next = ST_XTAL_WAIT;
                end else if (src_change) begin
                    state_next = ST_SW_OLD;
                end
            end
            ST_SW_OLD: begin
                // wait for edge of current clock
                if (cur_tick || fail_reg) begin
                    state_next = ST_SW_NEW;
                end
            end
            ST_SW_NEW: begin
                // new internal clock must be stable first
                if (!want_int || new_stable) begin
                    if (want_int ? int_tick : ext_tick) begin
                        state_next = ST_RUN;
                    end
                end
            end
            default: state_next = ST_POWER_UP;
        endcase
    end

    // bus read mux, bit 7 and upper bits zero
    // unimplemented bit reads zero
    wire [7:0] ctrl_rd = {1'b0, freq_sel_reg, startup_status_reg,
        hf_stable_reg, lf_stable_reg, clk_sel_reg};
    wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd}
        : hit_fail ? {31'h00000000, fail_reg} : 32'h00000000;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && !(hit_ctrl || hit_fail);
            o_prdata <= setup ? rd_mux : 32'h00000000;
        end
    end

    // software control bits
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            freq_sel_reg <= FREQ_SEL_RESET;
            clk_sel_reg <= 1'b0;
        end else if (wr_ctrl) begin
            freq_sel_reg <= i_pwdata[FREQ_SEL_MSB:FREQ_SEL_LSB];
            clk_sel_reg <= i_pwdata[CLK_SEL_BIT];
        end
    end

    // sticky fail flag: a trip beats a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fail_reg <= 1'b0;
        end else if (monitor_trip) begin
            fail_reg <= 1'b1;
        end else if (clr_fail) begin
            fail_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            monitor_gap_reg <= '0;
        end else if (ext_tick || cur_int_reg) begin
            monitor_gap_reg <= '0;
        end else if (!monitor_trip) begin
            monitor_gap_reg <= monitor_gap_reg + CNT_W'(1);
        end
    end

    // warm-up counters give the stable bits
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hf_warm_reg <= '0;
            lf_warm_reg <= '0;
            hf_stable_reg <= 1'b0;
            lf_stable_reg <= 1'b0;
        end else begin
            hf_warm_reg <= !hf_on ? '0 : (hf_stable_reg ? hf_warm_reg
                : hf_warm_reg + WARM_W'(1));
            hf_stable_reg <= hf_on && (hf_stable_reg
                || hf_warm_reg == WARM_W'(HF_WARM_CYC - 1));
            lf_warm_reg <= !lf_on ? '0 : (lf_stable_reg ? lf_warm_reg
                : lf_warm_reg + WARM_W'(1));
            lf_stable_reg <= lf_on && (lf_stable_reg
                || lf_warm_reg == WARM_W'(LF_WARM_CYC - 1));
        end
    end

    // start-up sequencing and source switching
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= ST_POWER_UP;
            cnt_reg <= '0;
            cur_int_reg <= 1'b0;
            cur_freq_sel_reg <= FREQ_SEL_RESET;
            osc_in_reg <= 1'b0;
            boot_reg <= 1'b0;
            startup_status_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            osc_in_reg <= i_osc_input_pin;
            boot_reg <= 1'b1;
            startup_status_reg <= boot_reg ? run_ext : startup_status_boot;
            if (state_next != state_reg) begin
                cnt_reg <= '0;
            end else if (state_reg == ST_POWER_UP) begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end else if (state_reg == ST_XTAL_WAIT && ext_tick) begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end
            // two-speed or a fail-safe trip runs internal during start-up
            if (state_reg != ST_RUN && state_reg != ST_SW_OLD) begin
                cur_int_reg <= want_int;
                cur_freq_sel_reg <= freq_sel_reg;
            end
            if (monitor_trip) begin
                cur_int_reg <= 1'b1;
            end
        end
    end

    // system clock enable and divided output
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sys_clk_en <= 1'b0;
            o_cpu_hold <= 1'b1;
            div_reg <= 2'h0;
            o_divided_clock_out <= 1'b0;
        end else begin
            o_cpu_hold <= hold;
            // on the external source, no input edges means no ticks
            o_sys_clk_en <= cur_tick && !hold;
            if (state_reg == ST_SW_NEW || hold) begin
                div_reg <= 2'h0;
                o_divided_clock_out <= 1'b0;
            end else if (cur_tick) begin
                div_reg <= div_reg + 2'h1;
                if (div_reg[0]) begin
                    o_divided_clock_out <= !o_divided_clock_out;
                end
            end
        end
    end

    // pin roles per mode
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_osc_output_pin_oe <= 1'b0;
            o_osc_output_pin_gpio <= 1'b0;
            o_osc_input_pin_gpio <= 1'b0;
            o_clk_internal <= 1'b0;
        end else begin
            o_osc_output_pin_oe <= has_divided_clock_out(i_osc_mode);
            o_osc_output_pin_gpio <= !crystal && !has_divided_clock_out(i_osc_mode);
            o_osc_input_pin_gpio <= int_mode;
            o_clk_internal <= cur_int_reg;
        end
    end
endmodule // system_clock_source_control
`default_nettype wire

// >>> testbench/clock_source_model.sv
/*
 * Model of the external clock source: a square wave on the oscillator
 * input. Assumes the bench clock; stands low while stopped.
 */
`timescale 1ns/1ps
`default_nettype none
module clock_source_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [7:0] i_half,
    output logic o_pin
);
    logic [7:0] cnt_reg;
    always_ff @(posedge i_clk) begin
        if (!i_run) begin
            cnt_reg <= 8'h00;
            o_pin <= 1'h0;
        end else if (cnt_reg + 8'h01 >= i_half) begin
            cnt_reg <= 8'h00;
            o_pin <= ~o_pin;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule // clock_source_model
`default_nettype wire

// >>> testbench/clk_ctrl_chk.sv
/*
 * Port checker for the clock source control block.
 * Assumes it is bound into the top module.
 */
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_chk
    import osc_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire osc_ctrl_pkg::osc_mode_t i_osc_mode,
    input wire logic i_osc_input_pin,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_sys_clk_en,
    input wire logic o_cpu_hold,
    input wire logic o_osc_output_pin_oe,
    input wire logic o_osc_output_pin_gpio,
    input wire logic o_osc_input_pin_gpio,
    input wire logic o_clk_internal
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire ext_m = i_osc_mode == EXTERNAL_LOGIC_CLOCK_MODE;
    wire int_m = i_osc_mode inside {INTERNAL_OSC_IO_MODE,
        INTERNAL_OSC_DIVIDED_CLOCK_OUT_MODE};
    wire co_m = i_osc_mode inside {INTERNAL_OSC_DIVIDED_CLOCK_OUT_MODE,
        RESISTOR_CAPACITOR_MODE};
    wire io_m = i_osc_mode inside {INTERNAL_OSC_IO_MODE, RESISTOR_NET_IO_MODE};
    wire xtl_m = i_osc_mode inside {LOW_POWER_CRYSTAL_MODE,
        MEDIUM_GAIN_CRYSTAL_MODE, HIGH_GAIN_CRYSTAL_MODE};
    bit7_zero_a: assert property (o_pready |-> o_prdata[31:7] == 25'h0)
        else $error("upper read bits set");
    hold_tick_a: assert property (o_cpu_hold |-> !o_sys_clk_en)
        else $error("tick while held");
    ext_pins_a: assert property (ext_m |=> o_osc_output_pin_gpio
        && !o_osc_output_pin_oe) else $error("ext mode pins wrong");
    divided_clock_out_a: assert property (co_m |=> o_osc_output_pin_oe
        && !o_osc_output_pin_gpio) else $error("clock out pin idle");
    io_pins_a: assert property (io_m |=> o_osc_output_pin_gpio)
        else $error("io mode pin not released");
    int_in_a: assert property (int_m |=> o_osc_input_pin_gpio)
        else $error("input pin not released");
    xtal_pins_a: assert property (xtl_m |=> !o_osc_output_pin_oe
        && !o_osc_output_pin_gpio) else $error("crystal pins misused");
    ext_tick_a: assert property (o_sys_clk_en && ext_m && !o_clk_internal
        |-> $past(i_osc_input_pin, 1) && !$past(i_osc_input_pin, 2))
        else $error("tick without input rise");
endmodule // clk_ctrl_chk
bind system_clock_source_control clk_ctrl_chk u_chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_osc_mode(i_osc_mode),
    .i_osc_input_pin(i_osc_input_pin), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_sys_clk_en(o_sys_clk_en),
    .o_cpu_hold(o_cpu_hold), .o_osc_output_pin_oe(o_osc_output_pin_oe),
    .o_osc_output_pin_gpio(o_osc_output_pin_gpio),
    .o_osc_input_pin_gpio(o_osc_input_pin_gpio),
    .o_clk_internal(o_clk_internal)
);
`default_nettype wire

// >>> testbench/system_clock_source_control_bench.sv
/*
 * Self-checking bench for the clock source control block.
 * Assumes the source model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control_bench;
    import osc_ctrl_pkg::*;
    logic clk, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic fs = 1'h0, power_up_timer = 1'h1, wake = 1'h0, xrun = 1'h0, pin_q = 1'h0;
    logic ts = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] xhalf = 8'h03;
    logic pready, pslverr, pin, tick, hold, dco, cint, err;
    osc_mode_t mode = EXTERNAL_LOGIC_CLOCK_MODE;
    int n_fail = 0, cmp_count = 0, cyc = 0, rises = 0, ticks = 0, g;
    system_clock_source_control #(
        .POWER_UP_CYCLES(8), .MONITOR_TIMEOUT(50)) dut (
        .i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_osc_mode(mode), .i_two_speed_en(ts), .i_failsafe_en(fs),
        .i_power_up_timer_en(power_up_timer), .i_wake(wake), .i_osc_input_pin(pin),
        .o_sys_clk_en(tick), .o_cpu_hold(hold), .o_divided_clock_out(dco),
        .o_osc_output_pin_oe(), .o_osc_output_pin_gpio(),
        .o_osc_input_pin_gpio(), .o_clk_internal(cint));
    clock_source_model src (.i_clk(clk), .i_run(xrun), .i_half(xhalf),
        .o_pin(pin));
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rises <= rises + int'(pin === 1'h1 && pin_q === 1'h0);
        ticks <= ticks + int'(tick === 1'h1);
        pin_q <= pin;
    end
    task automatic complete_run();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        for (int n = 0; s !== v; n++) begin
            if (n == lim) begin
                n_fail++;
                $display("mismatch at %0t: wait timed out", $time);
                complete_run();
            end
            @(posedge clk);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        wait_lvl(pready, 1'h1, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic gap(ref logic s, output int gv);
        int t0;
        wait_lvl(s, 1'h0, 4000);
        wait_lvl(s, 1'h1, 4000);
        t0 = cyc;
        wait_lvl(s, 1'h0, 4000);
        wait_lvl(s, 1'h1, 4000);
        gv = cyc - t0;
    endtask
    task automatic do_reset(input osc_mode_t m, input logic f, input logic p);
        nrst <= 1'h0;
        mode <= m;
        fs <= f;
        power_up_timer <= p;
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
    endtask
    task automatic s_regs();
        apb(1'h0, 12'h000, 32'h0);
        chk(rd & 32'hFFFF_FFF7, 32'h0000_0060);
        apb(1'h0, 12'h010, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        wait_lvl(hold, 1'h0, 40);
        apb(1'h1, 12'h000, 32'h0000_008E);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0008);
    endtask
    task automatic s_ext();
        int r0;
        int t0;
        r0 = rises;
        t0 = ticks;
        xrun <= 1'h1;
        repeat (200) @(posedge clk);
        xrun <= 1'h0;
        repeat (100) @(posedge clk);
        chk(ticks - t0, rises - r0);
        chk({hold, cint, tick}, 3'h0);
    endtask
    task automatic s_sweep();
        do_reset(INTERNAL_OSC_DIVIDED_CLOCK_OUT_MODE, 1'h0, 1'h1);
        apb(1'h1, 12'h000, 32'h0000_0071);
        wait_lvl(cint, 1'h1, 400);
        repeat (100) @(posedge clk);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd & 32'h0000_000D, 32'h0000_0005);
        gap(dco, g);
        chk(g, 4 * HF_BASE_DIV);
        for (int c = 7; c >= 0; c--) begin
            apb(1'h1, 12'h000, {25'h0, c[2:0], 4'h1});
            gap(tick, g);
            gap(tick, g);
            chk(g, c == 0 ? LF_DIV : HF_BASE_DIV << (7 - c));
        end
        apb(1'h0, 12'h000, 32'h0);
        chk(rd[1], 1'h1);
    endtask
    task automatic s_xtal();
        int r0;
        xhalf <= 8'h02;
        xrun <= 1'h1;
        do_reset(LOW_POWER_CRYSTAL_MODE, 1'h0, 1'h0);
        for (int k = 0; k < 2; k++) begin
            r0 = rises;
            wait_lvl(hold, 1'h0, 6000);
            chk(rises - r0 inside {[1022:1026]}, 1'h1);
            wake <= 1'h1;
            @(posedge clk);
            wake <= 1'h0;
            wait_lvl(hold, 1'h1, 8);
        end
    endtask
    task automatic s_two();
        ts <= 1'h1;
        do_reset(LOW_POWER_CRYSTAL_MODE, 1'h0, 1'h0);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd[3], 1'h0);
        chk(hold, 1'h0);
    endtask
    task automatic s_fail();
        ts <= 1'h0;
        xrun <= 1'h0;
        do_reset(RESISTOR_NET_IO_MODE, 1'h1, 1'h1);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd[3], 1'h0);
        xrun <= 1'h1;
        wait_lvl(hold, 1'h0, 40);
        repeat (60) @(posedge clk);
        chk(cint, 1'h0);
        xrun <= 1'h0;
        wait_lvl(cint, 1'h1, 300);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd[0], 1'h1);
        apb(1'h1, 12'h004, 32'h1);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd[0], 1'h0);
    endtask
    initial begin
        do_reset(EXTERNAL_LOGIC_CLOCK_MODE, 1'h0, 1'h1);
        s_regs();
        s_ext();
        s_sweep();
        s_xtal();
        s_two();
        s_fail();
        complete_run();
    end
endmodule // system_clock_source_control_bench
`default_nettype wire
